// ### hdl/oel_ctrl_regs.sv
`timescale 1ns/1ps
module oel_ctrl_regs
   import oel_pkg::*;
#(
   parameter int RST_CYCLES = SOFT_RST_CYCLES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // host register port
   input wire logic [7:0] hostAddr,
   input wire logic [7:0] hostWrData,
   input wire logic hostWrEn,
   input wire logic hostRdEn,
   output logic [7:0] hostRdData,
   output logic hostRdHit,
   output logic bankExpanded,
   // channel status from the line side
   input wire logic [NCH-1:0] driverFaultStatus,
   input wire logic [NCH-1:0] driverFaultMask,
   input wire logic [NCH-1:0] alarmIndicationStatus,
   input wire logic [NCH-1:0] dropoutState,
   // soft reset to the rest of the device
   output logic softResetActive,
   // per-channel controls
   output logic [NCH-1:0] loopbackEn,
   output logic [NCH-1:0] criteriaEtsi,
   output logic [NCH-1:0] autoAllOnesTx,
   output logic [NCH-1:0] txHighZ,
   output logic [NCH-1:0] systemAlarmInsert,
   // monitor routing
   output logic monitorEn,
   output logic monitorTx,
   output logic [2:0] monitorChannel,
   // global controls
   output logic shortProtectEn,
   output logic amiSel,
   output logic jitterFifoDeep,
   output logic jitterBandwidthWide,
   output logic jitterTxPath,
   output logic jitterRxPath
);
   typedef struct packed {
      logic [7:0] bankPointer;
      logic [MON_W-1:0] monitorSelect;
      logic [NCH-1:0] loopback;
      logic [NCH-1:0] criteria;
      logic [NCH-1:0] allOnes;
      logic [6:0] globalConfig;
      logic [NCH-1:0] highZ;
      logic [NCH-1:0] alarmMask;
      logic [7:0] rdData;
      logic rdHit;
      logic [NCH-1:0] allOnesTx;
      logic [NCH-1:0] alarmInsert;
      logic monEn;
      logic monTx;
      logic [2:0] monChan;
   } oel_regs_t;

   oel_regs_t r_q;
   oel_regs_t r_d;

   logic primary;
   logic wrStrobe;
   logic rdStrobe;
   logic resetTrigger;
   logic swActive;

   ////////////////////////////////////////////////////////////////////////
   // address decode

   // one select line per offset served or watched by this bank
   typedef struct packed {
      logic bankPtr;
      logic faultStatus;
      logic faultIrq;
      logic softReset;
      logic monitor;
      logic loopback;
      logic criteria;
      logic allOnes;
      logic globalCfg;
      logic highZ;
      logic alarmStatus;
      logic alarmMask;
      logic alarmIrq;
   } oel_sel_t;

   oel_sel_t sel;

   always_comb begin
      sel = '0;
      if (hostAddr == ADR_BANK_PTR) begin
         sel.bankPtr = 1'b1;
      end else if (hostAddr == ADR_FAULT_STATUS) begin
         sel.faultStatus = 1'b1;
      end else if (hostAddr == ADR_FAULT_IRQ) begin
         sel.faultIrq = 1'b1;
      end else if (hostAddr == ADR_SOFT_RESET) begin
         sel.softReset = 1'b1;
      end else if (hostAddr == ADR_MONITOR) begin
         sel.monitor = 1'b1;
      end else if (hostAddr == ADR_LOOPBACK) begin
         sel.loopback = 1'b1;
      end else if (hostAddr == ADR_CRITERIA) begin
         sel.criteria = 1'b1;
      end else if (hostAddr == ADR_ALL_ONES) begin
         sel.allOnes = 1'b1;
      end else if (hostAddr == ADR_GLOBAL) begin
         sel.globalCfg = 1'b1;
      end else if (hostAddr == ADR_HIGHZ) begin
         sel.highZ = 1'b1;
      end else if (hostAddr == ADR_ALARM_STATUS) begin
         sel.alarmStatus = 1'b1;
      end else if (hostAddr == ADR_ALARM_MASK) begin
         sel.alarmMask = 1'b1;
      end else if (hostAddr == ADR_ALARM_IRQ) begin
         sel.alarmIrq = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bank select and strobes

   // only the pointer is reachable while the expanded bank is selected
   assign primary = (r_q.bankPointer != PTR_EXPANDED);
   assign wrStrobe = hostWrEn & ~swActive;
   assign rdStrobe = hostRdEn;
   // trigger only, data is dropped
   assign resetTrigger = hostWrEn & primary
                       & sel.softReset;

   ////////////////////////////////////////////////////////////////////////
   // soft reset pulse

   oel_soft_reset #(
      .CYCLES(RST_CYCLES)
   ) u_soft_reset (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .trigger(resetTrigger),
      .active(swActive)
   );

   ////////////////////////////////////////////////////////////////////////
   // change interrupts

   oel_evt_if #(.N(NCH)) faultEv ();
   oel_evt_if #(.N(NCH)) alarmEv ();

   assign faultEv.status = driverFaultStatus;
   assign faultEv.mask = driverFaultMask;
   // reading the fault status clears the sticky bits
   assign faultEv.clr = rdStrobe & primary
                      & sel.faultStatus;
   assign faultEv.swRst = swActive;

   assign alarmEv.status = alarmIndicationStatus;
   assign alarmEv.mask = r_q.alarmMask;
   assign alarmEv.clr = rdStrobe & primary
                      & sel.alarmStatus;
   assign alarmEv.swRst = swActive;

   oel_change_irq #(
      .N(NCH)
   ) u_fault_irq (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ev(faultEv)
   );

   oel_change_irq #(
      .N(NCH)
   ) u_alarm_irq (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ev(alarmEv)
   );

   ////////////////////////////////////////////////////////////////////////
   // register update

   always_comb begin
      r_d = r_q;
      // writes
      if (wrStrobe && sel.bankPtr) begin
         r_d.bankPointer = hostWrData;
      end else if (wrStrobe && primary) begin
         if (sel.monitor) begin
            // upper nibble reserved, not stored
            r_d.monitorSelect = hostWrData[MON_W-1:0];
         end else if (sel.loopback) begin
            r_d.loopback = hostWrData;
         end else if (sel.criteria) begin
            r_d.criteria = hostWrData;
         end else if (sel.allOnes) begin
            r_d.allOnes = hostWrData;
         end else if (sel.globalCfg) begin
            // bit 7 reserved, not stored
            r_d.globalConfig = hostWrData[6:0];
         end else if (sel.highZ) begin
            r_d.highZ = hostWrData;
         end else if (sel.alarmMask) begin
            r_d.alarmMask = hostWrData;
         end
      end

      // reads
      r_d.rdHit = 1'b0;
      r_d.rdData = r_q.rdData;
      if (rdStrobe) begin
         r_d.rdHit = 1'b1;
         if (sel.bankPtr) begin
            r_d.rdData = r_q.bankPointer;
         end else if (!primary) begin
            r_d.rdHit = 1'b0;
            r_d.rdData = RD_UNMAPPED;
         end else if (sel.faultIrq) begin
            r_d.rdData = faultEv.irq;
         end else if (sel.softReset) begin
            r_d.rdData = SOFT_RESET_RD;
         end else if (sel.monitor) begin
            r_d.rdData = {4'h0, r_q.monitorSelect};
         end else if (sel.loopback) begin
            r_d.rdData = r_q.loopback;
         end else if (sel.criteria) begin
            r_d.rdData = r_q.criteria;
         end else if (sel.allOnes) begin
            r_d.rdData = r_q.allOnes;
         end else if (sel.globalCfg) begin
            r_d.rdData = {1'b0, r_q.globalConfig};
         end else if (sel.highZ) begin
            r_d.rdData = r_q.highZ;
         end else if (sel.alarmStatus) begin
            r_d.rdData = alarmIndicationStatus;
         end else if (sel.alarmMask) begin
            r_d.rdData = r_q.alarmMask;
         end else if (sel.alarmIrq) begin
            r_d.rdData = alarmEv.irq;
         end else begin
            r_d.rdHit = 1'b0;
            r_d.rdData = RD_UNMAPPED;
         end
      end

      // derived controls, registered
      r_d.allOnesTx = r_q.allOnes & dropoutState;
      r_d.alarmInsert = {NCH{r_q.globalConfig[GLB_ALARM_INS]}}
                      & dropoutState;
      // codes 0 and 8 mean no monitoring
      r_d.monEn = (r_q.monitorSelect[2:0] != MON_CH_NONE);
      r_d.monTx = r_q.monitorSelect[MON_DIR_BIT];
      r_d.monChan = r_q.monitorSelect[2:0];

      // soft reset pulse returns everything but the read data and hit to defaults
      if (swActive) begin
         r_d.bankPointer = PTR_PRIMARY;
         r_d.monitorSelect = MON_RST;
         r_d.loopback = BYTE_RST;
         r_d.criteria = BYTE_RST;
         r_d.allOnes = BYTE_RST;
         r_d.globalConfig = GLB_RST;
         r_d.highZ = BYTE_RST;
         r_d.alarmMask = BYTE_RST;
         r_d.allOnesTx = '0;
         r_d.alarmInsert = '0;
         r_d.monEn = 1'b0;
         r_d.monTx = 1'b0;
         r_d.monChan = MON_CH_NONE;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         r_q <= '{
            bankPointer: PTR_PRIMARY,
            monitorSelect: MON_RST,
            loopback: BYTE_RST,
            criteria: BYTE_RST,
            allOnes: BYTE_RST,
            globalConfig: GLB_RST,
            highZ: BYTE_RST,
            alarmMask: BYTE_RST,
            rdData: RD_UNMAPPED,
            rdHit: 1'b0,
            allOnesTx: '0,
            alarmInsert: '0,
            monEn: 1'b0,
            monTx: 1'b0,
            monChan: MON_CH_NONE
         };
      end else begin
         r_q <= r_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign hostRdData = r_q.rdData;
   assign hostRdHit = r_q.rdHit;
   assign bankExpanded = ~primary;
   assign softResetActive = swActive;

   assign loopbackEn = r_q.loopback;
   assign criteriaEtsi = r_q.criteria;
   assign autoAllOnesTx = r_q.allOnesTx;
   assign txHighZ = r_q.highZ;
   assign systemAlarmInsert = r_q.alarmInsert;

   assign monitorEn = r_q.monEn;
   assign monitorTx = r_q.monTx;
   assign monitorChannel = r_q.monChan;

   assign shortProtectEn = ~r_q.globalConfig[GLB_SHORT_BYP];
   assign amiSel = r_q.globalConfig[GLB_LINE_AMI];
   assign jitterFifoDeep = r_q.globalConfig[GLB_FIFO_DEEP];
   assign jitterBandwidthWide = r_q.globalConfig[GLB_BW_WIDE];
   assign jitterTxPath = (r_q.globalConfig[GLB_PATH_HI:GLB_PATH_LO]
                         == JA_PATH_TX);
   assign jitterRxPath = (r_q.globalConfig[GLB_PATH_HI:GLB_PATH_LO]
                         == JA_PATH_RX);
endmodule // oel_ctrl_regs

// ### common/oel_pkg.sv
package oel_pkg;
   localparam int NCH = 8;
   // register offsets, primary bank
   localparam logic [7:0] ADR_FAULT_STATUS = 8'h05;
   localparam logic [7:0] ADR_FAULT_IRQ = 8'h09;
   localparam logic [7:0] ADR_SOFT_RESET = 8'h0a;
   localparam logic [7:0] ADR_MONITOR = 8'h0b;
   localparam logic [7:0] ADR_LOOPBACK = 8'h0c;
   localparam logic [7:0] ADR_CRITERIA = 8'h0d;
   localparam logic [7:0] ADR_ALL_ONES = 8'h0e;
   localparam logic [7:0] ADR_GLOBAL = 8'h0f;
   localparam logic [7:0] ADR_HIGHZ = 8'h12;
   localparam logic [7:0] ADR_ALARM_STATUS = 8'h13;
   localparam logic [7:0] ADR_ALARM_MASK = 8'h14;
   localparam logic [7:0] ADR_ALARM_IRQ = 8'h15;
   localparam logic [7:0] ADR_BANK_PTR = 8'h1f;
   // reset values
   localparam logic [7:0] SOFT_RESET_RD = 8'hff;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   localparam logic [3:0] MON_RST = 4'h0;
   localparam logic [6:0] GLB_RST = 7'h00;
   localparam logic [7:0] PTR_PRIMARY = 8'h00;
   localparam logic [7:0] PTR_EXPANDED = 8'haa;
   // monitor select field
   localparam int MON_W = 4;
   localparam int MON_DIR_BIT = 3;
   localparam logic [2:0] MON_CH_NONE = 3'h0;
   // global config field positions
   localparam int GLB_ALARM_INS = 6;
   localparam int GLB_SHORT_BYP = 5;
   localparam int GLB_LINE_AMI = 4;
   localparam int GLB_FIFO_DEEP = 3;
   localparam int GLB_BW_WIDE = 2;
   localparam int GLB_PATH_HI = 1;
   localparam int GLB_PATH_LO = 0;
   localparam logic [1:0] JA_PATH_TX = 2'b01;
   localparam logic [1:0] JA_PATH_RX = 2'b11;
   // timing
   localparam int CLK_MHZ = 125;
   localparam int SOFT_RST_US = 1;
   localparam int SOFT_RST_CYCLES = SOFT_RST_US * CLK_MHZ;
   typedef enum logic [1:0] {
      RST_IDLE = 2'b01,
      RST_BUSY = 2'b10
   } oel_rst_state_t;
endpackage

// ### common/oel_evt_if.sv
`timescale 1ns/1ps
interface oel_evt_if #(parameter int N = 8);
   logic [N-1:0] status;
   logic [N-1:0] mask;
   logic [N-1:0] irq;
   logic clr;
   logic swRst;
   modport host (output status, output mask, output clr, output swRst,
                 input irq);
   modport det (input status, input mask, input clr, input swRst,
                output irq);
endinterface

// ### hdl/oel_change_irq.sv
`timescale 1ns/1ps
module oel_change_irq
   import oel_pkg::*;
#(
   parameter int N = NCH
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // status, mask and sticky bits
   oel_evt_if.det ev
);
   typedef struct packed {
      logic [N-1:0] prev;
      logic [N-1:0] irq;
   } oel_chg_t;

   oel_chg_t r_q;
   oel_chg_t r_d;

   always_comb begin
      r_d = r_q;
      r_d.prev = ev.status;
      // set wins over a clear in the same cycle
      r_d.irq = (r_q.irq & ~{N{ev.clr}})
              | ((r_q.prev ^ ev.status) & ev.mask);
      if (ev.swRst) begin
         r_d.irq = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign ev.irq = r_q.irq;
endmodule // oel_change_irq

// ### hdl/oel_soft_reset.sv
`timescale 1ns/1ps
module oel_soft_reset
   import oel_pkg::*;
#(
   parameter int CYCLES = SOFT_RST_CYCLES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // trigger and pulse
   input wire logic trigger,
   output logic active
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   typedef struct packed {
      oel_rst_state_t state;
      logic [CW-1:0] cnt;
   } oel_srst_t;

   oel_srst_t r_q;
   oel_srst_t r_d;

   always_comb begin
      r_d = r_q;
      case (r_q.state)
         RST_IDLE: begin
            if (trigger) begin
               r_d.state = RST_BUSY;
               r_d.cnt = '0;
            end
         end
         RST_BUSY: begin
            if (trigger) begin
               r_d.cnt = '0;
            end else if (r_q.cnt == LAST) begin
               r_d.state = RST_IDLE;
            end else begin
               r_d.cnt = r_q.cnt + CW'(1);
            end
         end
         default: begin
            r_d.state = RST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         r_q <= '{state: RST_IDLE, cnt: '0};
      end else begin
         r_q <= r_d;
      end
   end

   assign active = (r_q.state == RST_BUSY);
endmodule // oel_soft_reset

// ### test/oel_ctrl_regs_checker.sv
`timescale 1ns/1ps
module oel_ctrl_regs_checker
   import oel_pkg::*;
#(
   parameter int RST_CYCLES = SOFT_RST_CYCLES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // observed ports
   input wire logic [7:0] hostAddr,
   input wire logic [7:0] hostWrData,
   input wire logic hostWrEn,
   input wire logic hostRdEn,
   input wire logic [7:0] hostRdData,
   input wire logic hostRdHit,
   input wire logic bankExpanded,
   input wire logic [NCH-1:0] dropoutState,
   input wire logic softResetActive,
   input wire logic [NCH-1:0] loopbackEn,
   input wire logic [NCH-1:0] autoAllOnesTx,
   input wire logic [NCH-1:0] systemAlarmInsert,
   input wire logic monitorEn,
   input wire logic monitorTx,
   input wire logic [2:0] monitorChannel,
   input wire logic shortProtectEn,
   input wire logic amiSel,
   input wire logic jitterTxPath,
   input wire logic jitterRxPath
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic wrOk;
   logic trig;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   assign wrOk = hostWrEn && !bankExpanded && !softResetActive;
   assign trig = hostWrEn && !bankExpanded && hostAddr == ADR_SOFT_RESET;
   // counts pulse cycles since the last trigger
   always_comb begin
      cnt_d = cnt_q;
      if (trig)
         cnt_d = '0;
      else if (softResetActive)
         cnt_d = cnt_q + 16'h1;
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end
   ////////////////////////////////////////////////////////////////////////
   a_soft_start: assert property (trig |=> softResetActive)
      else $error("soft reset pulse did not start");
   a_soft_length: assert property (
      $fell(softResetActive) |-> cnt_q == RST_CYCLES)
      else $error("soft reset pulse length wrong");
   a_trigger_reads_ff: assert property (
      hostRdEn && !bankExpanded && hostAddr == ADR_SOFT_RESET
      |=> hostRdHit && hostRdData == SOFT_RESET_RD)
      else $error("soft reset register content changed");
   a_expanded_miss: assert property (
      hostRdEn && bankExpanded && hostAddr != ADR_BANK_PTR
      |=> !hostRdHit && hostRdData == RD_UNMAPPED)
      else $error("primary register served in expanded bank");
   a_bank_select: assert property (
      hostWrEn && hostAddr == ADR_BANK_PTR && !softResetActive
      |=> bankExpanded == ($past(hostWrData) == PTR_EXPANDED))
      else $error("bank pointer decode wrong");
   a_loop_write: assert property (
      wrOk && hostAddr == ADR_LOOPBACK |=> loopbackEn == $past(hostWrData))
      else $error("loopback control not written");
   a_all_ones_gate: assert property (
      (autoAllOnesTx & ~$past(dropoutState)) == '0)
      else $error("all ones sent without dropout");
   a_alarm_gate: assert property (
      (systemAlarmInsert & ~$past(dropoutState)) == '0)
      else $error("alarm inserted without dropout");
   a_global_fields: assert property (
      wrOk && hostAddr == ADR_GLOBAL |=>
      shortProtectEn == !$past(hostWrData[GLB_SHORT_BYP]) &&
      amiSel == $past(hostWrData[GLB_LINE_AMI]) &&
      jitterTxPath == ($past(hostWrData[1:0]) == JA_PATH_TX) &&
      jitterRxPath == ($past(hostWrData[1:0]) == JA_PATH_RX))
      else $error("global field decode wrong");
   a_monitor_decode: assert property (
      wrOk && hostAddr == ADR_MONITOR |-> ##2
      monitorEn == ($past(hostWrData[2:0], 2) != MON_CH_NONE) &&
      (!monitorEn ||
       {monitorTx, monitorChannel} == $past(hostWrData[3:0], 2)))
      else $error("monitor decode wrong");
endmodule // oel_ctrl_regs_checker

// ### test/oel_host_model.sv
`timescale 1ns/1ps
module oel_host_model (
   // clock
   input wire logic clk_sys,
   // register port
   output logic [7:0] hostAddr,
   output logic [7:0] hostWrData,
   output logic hostWrEn,
   output logic hostRdEn
);
   initial begin
      hostAddr = 8'h00;
      hostWrData = 8'h00;
      hostWrEn = 1'b0;
      hostRdEn = 1'b0;
   end
   // one strobe cycle, then address and data scrambled
   task automatic access(input logic wr, input logic [7:0] a,
                         input logic [7:0] d);
      @(posedge clk_sys);
      hostWrEn <= wr;
      hostRdEn <= !wr;
      hostAddr <= a;
      hostWrData <= d;
      @(posedge clk_sys);
      hostWrEn <= 1'b0;
      hostRdEn <= 1'b0;
      hostAddr <= ~a;
      hostWrData <= ~d;
   endtask
endmodule // oel_host_model

// ### test/oel_ctrl_regs_test.sv
`timescale 1ns/1ps
module oel_ctrl_regs_test;
   import oel_pkg::*;
   localparam int RSTC = 8;
   logic clk_sys, nrst, hostWrEn, hostRdEn, hostRdHit, bankExpanded;
   logic [7:0] hostAddr, hostWrData, hostRdData, v, d;
   logic [NCH-1:0] driverFaultStatus, driverFaultMask, alarmIndicationStatus;
   logic [NCH-1:0] dropoutState, loopbackEn, criteriaEtsi, autoAllOnesTx;
   logic [NCH-1:0] txHighZ, systemAlarmInsert;
   logic softResetActive, monitorEn, monitorTx, shortProtectEn, amiSel;
   logic jitterFifoDeep, jitterBandwidthWide, jitterTxPath, jitterRxPath;
   logic [2:0] monitorChannel;
   logic [7:0] expQ[$];
   logic [7:0] adrs[11] = '{ADR_SOFT_RESET, ADR_FAULT_IRQ, ADR_MONITOR,
      ADR_LOOPBACK, ADR_CRITERIA, ADR_ALL_ONES, ADR_GLOBAL, ADR_HIGHZ,
      ADR_ALARM_STATUS, ADR_ALARM_MASK, ADR_ALARM_IRQ};
   logic [7:0] rwA[4] = '{ADR_LOOPBACK, ADR_CRITERIA, ADR_HIGHZ,
      ADR_ALARM_MASK};
   int err_count, checked, cyc, actCnt;
   integer seed;
   oel_ctrl_regs #(.RST_CYCLES(RSTC)) dut (.clk_sys, .nrst, .hostAddr,
      .hostWrData, .hostWrEn, .hostRdEn, .hostRdData, .hostRdHit, .bankExpanded,
      .driverFaultStatus, .driverFaultMask, .alarmIndicationStatus,
      .dropoutState, .softResetActive, .loopbackEn, .criteriaEtsi,
      .autoAllOnesTx, .txHighZ, .systemAlarmInsert, .monitorEn, .monitorTx,
      .monitorChannel, .shortProtectEn, .amiSel, .jitterFifoDeep,
      .jitterBandwidthWide, .jitterTxPath, .jitterRxPath);
   oel_host_model host (.clk_sys, .hostAddr, .hostWrData, .hostWrEn, .hostRdEn);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] dd);
      host.access(1'b1, a, dd);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expQ.push_back(e);
      host.access(1'b0, a, 8'h00);
   endtask
   task automatic rdMiss(input logic [7:0] a);
      host.access(1'b0, a, 8'h00);
      #1;
      chk(hostRdHit, 8'h00);
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic results();
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // read results against the oldest note
   always @(posedge clk_sys) begin
      cyc++;
      if (softResetActive === 1'b1)
         actCnt++;
      if (hostRdHit === 1'b1) begin
         if (expQ.size() > 0)
            chk(hostRdData, expQ.pop_front());
         else
            chk(hostRdHit, 8'h00);
      end
      if (cyc == 20000) begin
         err_count++;
         $display("BAD %0t run did not finish", $time);
         results();
      end
   end
   initial begin
      seed = 32'h4c47;
      nrst = 1'b0;
      driverFaultStatus = '0;
      driverFaultMask = 8'h81;
      alarmIndicationStatus = '0;
      dropoutState = '0;
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      foreach (adrs[i])
         rd(adrs[i], i == 0 ? SOFT_RESET_RD : BYTE_RST);
      rdMiss(8'h30);
      $display("test defaults done");
      foreach (rwA[i]) begin
         v = 8'($random(seed));
         wr(rwA[i], v);
         case (i)
            0: chk(loopbackEn, v);
            1: chk(criteriaEtsi, v);
            2: chk(txHighZ, v);
            default: ;
         endcase
         rd(rwA[i], v);
      end
      $display("test channel registers done");
      for (int i = 0; i < 4; i++) begin
         d = {1'b1, i[0], ~i[0], i[0], ~i[0], i[0], i[1:0]};
         wr(ADR_GLOBAL, d);
         chk(shortProtectEn, !d[5]);
         chk(amiSel, d[4]);
         chk(jitterFifoDeep, d[3]);
         chk(jitterBandwidthWide, d[2]);
         chk({jitterRxPath, jitterTxPath},
             {d[1:0] == 2'b11, d[1:0] == 2'b01});
         rd(ADR_GLOBAL, d & 8'h7f);
      end
      v = 8'($random(seed));
      wr(ADR_ALL_ONES, v);
      repeat (3) begin
         @(posedge clk_sys);
         dropoutState <= 8'($random(seed));
         step(2);
         chk(autoAllOnesTx, v & dropoutState);
         chk(systemAlarmInsert, dropoutState);
      end
      wr(ADR_GLOBAL, 8'h00);
      step(2);
      chk(systemAlarmInsert, 8'h00);
      $display("test global and dropout done");
      for (int c = 0; c < 16; c++) begin
         wr(ADR_MONITOR, {4'hf, c[3:0]});
         step(1);
         chk(monitorEn, c[2:0] != 3'h0);
         if (c[2:0] != 3'h0)
            chk({monitorTx, monitorChannel}, c[3:0]);
         rd(ADR_MONITOR, {4'h0, c[3:0]});
      end
      $display("test monitor done");
      wr(ADR_BANK_PTR, PTR_EXPANDED);
      chk(bankExpanded, 8'h01);
      rdMiss(ADR_LOOPBACK);
      wr(ADR_BANK_PTR, PTR_PRIMARY);
      chk(bankExpanded, 8'h00);
      $display("test bank pointer done");
      wr(ADR_ALARM_MASK, 8'h05);
      @(posedge clk_sys);
      alarmIndicationStatus <= 8'h07;
      step(2);
      @(posedge clk_sys);
      alarmIndicationStatus <= 8'h06;
      rd(ADR_ALARM_IRQ, 8'h05);
      rd(ADR_ALARM_IRQ, 8'h05);
      wr(ADR_ALARM_STATUS, 8'hff);
      rd(ADR_ALARM_STATUS, 8'h06);
      rd(ADR_ALARM_IRQ, 8'h00);
      @(posedge clk_sys);
      driverFaultStatus <= 8'h89;
      step(2);
      rd(ADR_FAULT_IRQ, 8'h81);
      rdMiss(ADR_FAULT_STATUS);
      rd(ADR_FAULT_IRQ, 8'h00);
      $display("test sticky bits done");
      wr(ADR_LOOPBACK, 8'hff);
      wr(ADR_SOFT_RESET, 8'h3c);
      wr(ADR_LOOPBACK, 8'h33);
      step(RSTC + 4);
      chk(8'(actCnt), 8'(RSTC));
      chk(loopbackEn, 8'h00);
      rd(ADR_ALARM_MASK, 8'h00);
      rd(ADR_SOFT_RESET, SOFT_RESET_RD);
      step(3);
      chk(8'(expQ.size()), 8'h00);
      $display("test soft reset done");
      results();
   end
endmodule // oel_ctrl_regs_test
bind oel_ctrl_regs oel_ctrl_regs_checker #(.RST_CYCLES(RST_CYCLES)) chk_i (
   .clk_sys, .nrst, .hostAddr, .hostWrData, .hostWrEn, .hostRdEn, .hostRdData,
   .hostRdHit, .bankExpanded, .dropoutState, .softResetActive, .loopbackEn,
   .autoAllOnesTx, .systemAlarmInsert, .monitorEn, .monitorTx, .monitorChannel,
   .shortProtectEn, .amiSel, .jitterTxPath, .jitterRxPath);
